/* File: bench/asdma_far.sv */
`timescale 1ns/1ps
module asdma_far (
   input  wire logic clk,             // Clock.
   input  wire logic line_in,         // Line from the port.
   output logic      line_out         // Line to the port.
);
   initial line_out = 1'b1;

   // The caller packs parity or a ninth bit into v, so any frame of up to ten bits can be sent.
   task automatic send(input int n, input logic [9:0] v, input int bt);
      line_out <= 1'b0;
      repeat (bt) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         line_out <= v[i];
         repeat (bt) @(posedge clk);
      end
      line_out <= 1'b1;
      repeat (bt) @(posedge clk);
   endtask : send

   task automatic recv(input int n, input int bt, output logic [9:0] v, output int lo);
      int t;
      v = 10'h000;
      lo = 0;
      t = 0;
      while (line_in !== 1'b0 && t < 20000) begin
         @(posedge clk);
         t++;
      end
      // Counting stops at one bit time so a low first data bit cannot stretch the start bit.
      while (line_in === 1'b0 && lo < bt) begin
         @(posedge clk);
         lo++;
      end
      repeat (bt / 2) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         v[i] = line_in;
         repeat (bt) @(posedge clk);
      end
   endtask : recv
endmodule : asdma_far

/* File: bench/tb.sv */
`timescale 1ns/1ps
module tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [4:0]  avs_address = 5'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic        dma_tx_ack = 1'b0;
   logic        dma_rx_ack = 1'b0;
   logic [8:0]  dma_tx_data = 9'h000;
   logic [31:0] avs_readdata, q;
   logic        avs_waitrequest, rxd, txd, dma_tx_req, dma_rx_req, tx_irq, rx_irq, rx_level;
   logic [8:0]  dma_rx_data;
   logic [1:0]  dma_prio;
   logic [9:0]  v;
   int          lo, num_errors = 0, samples_checked = 0;

   always #4 clk = ~clk;

   asdma_top asdma_top_inst (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .rxd(rxd), .txd(txd), .dma_tx_req(dma_tx_req),
      .dma_tx_ack(dma_tx_ack), .dma_tx_data(dma_tx_data), .dma_rx_req(dma_rx_req),
      .dma_rx_ack(dma_rx_ack), .dma_rx_data(dma_rx_data), .dma_prio(dma_prio), .tx_irq(tx_irq),
      .rx_irq(rx_irq), .rx_level(rx_level));
   asdma_far asdma_far_inst (.clk(clk), .line_in(txd), .line_out(rxd));

   task automatic end_sim();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_sim

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Called just after a rising edge; the request stands until the edge that sees waitrequest low,
   // and one more edge passes after the release so back-to-back calls never re-raise in one step.
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && n < 200) begin
         @(posedge clk);
         n++;
      end
      if (avs_waitrequest !== 1'b0) begin
         num_errors++;
         end_sim();
      end
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask : bus

   task automatic wait_rx();
      int n;
      n = 0;
      q = 32'h0;
      while (q[0] !== 1'b1 && n < 60) begin
         bus(1'b0, asdma_pkg::OFF_STAT, 32'h0, q);
         n++;
      end
      if (n == 60) begin
         num_errors++;
         end_sim();
      end
   endtask : wait_rx

   task automatic t_reset();
      bus(1'b0, asdma_pkg::OFF_CFG, 32'h0, q);
      chk("cfg", 32'h3, q);
      bus(1'b0, asdma_pkg::OFF_DIVL, 32'h0, q);
      chk("divl", 32'h1, q);
      bus(1'b0, 5'h1C, 32'h0, q);
      chk("unmapped", 32'h0, q);
      chk("prio", 32'h0, {30'h0, dma_prio});
      bus(1'b1, asdma_pkg::OFF_MASK, 32'h3, q);
      @(posedge clk);
      chk("tx irq", 32'h1, {31'h0, tx_irq});
      chk("rx level", 32'h1, {31'h0, rx_level});
   endtask : t_reset

   task automatic t_tx();
      bus(1'b1, asdma_pkg::OFF_DIVH, 32'h5A, q);
      bus(1'b0, asdma_pkg::OFF_DIVH, 32'h0, q);
      chk("divh", 32'h5A, q);
      bus(1'b1, asdma_pkg::OFF_DIVH, 32'h0, q);
      bus(1'b1, asdma_pkg::OFF_DIVL, 32'h2, q);
      fork
         bus(1'b1, asdma_pkg::OFF_TXD, 32'hA5, q);
         asdma_far_inst.recv(8, 32, v, lo);
      join
      chk("tx byte", 32'hA5, {22'h0, v});
      chk("bit time", 32'h20, 32'(lo));
      bus(1'b1, asdma_pkg::OFF_DIVL, 32'h1, q);
   endtask : t_tx

   task automatic t_rx();
      for (int w = 0; w < 4; w++) begin
         bus(1'b1, asdma_pkg::OFF_CFG, 32'(w), q);
         asdma_far_inst.send(w + 5, 10'h3A5, 16);
         wait_rx();
         chk("rx irq", 32'h1, {31'h0, rx_irq});
         bus(1'b0, asdma_pkg::OFF_RXD, 32'h0, q);
         chk("rx data", 32'h1A5 & ((32'h1 << (w + 5)) - 32'h1), q);
      end
      bus(1'b1, asdma_pkg::OFF_CFG, 32'h0B, q);
      asdma_far_inst.send(9, 10'h1A5, 16);
      wait_rx();
      chk("parity flag", 32'h1, {31'h0, q[5]});
      bus(1'b0, asdma_pkg::OFF_RXD, 32'h0, q);
      bus(1'b1, asdma_pkg::OFF_CFG, 32'h03, q);
      asdma_far_inst.send(9, 10'h0A5, 16);
      wait_rx();
      chk("framing flag", 32'h1, {31'h0, q[4]});
      bus(1'b0, asdma_pkg::OFF_RXD, 32'h0, q);
      bus(1'b1, asdma_pkg::OFF_CFG, 32'h27, q);
      asdma_far_inst.send(9, 10'h1A5, 16);
      wait_rx();
      chk("addr flag", 32'h1, {31'h0, q[6]});
      bus(1'b0, asdma_pkg::OFF_RXD, 32'h0, q);
      chk("rx addr word", 32'h1A5, q);
      bus(1'b1, asdma_pkg::OFF_STAT, 32'h38, q);
   endtask : t_rx

   task automatic t_dma();
      bus(1'b1, asdma_pkg::OFF_CFG, 32'hC3, q);
      @(posedge clk);
      chk("tx dma req", 32'h1, {31'h0, dma_tx_req});
      fork
         begin
            @(posedge clk);
            for (int i = 0; i < 3; i++) begin
               dma_tx_ack <= 1'b1;
               dma_tx_data <= 9'h0C3 + 9'(i);
               @(posedge clk);
            end
            dma_tx_ack <= 1'b0;
         end
         for (int i = 0; i < 3; i++) begin
            asdma_far_inst.recv(8, 16, v, lo);
            chk("dma tx", 32'hC3 + 32'(i), {22'h0, v});
            chk("dma bit time", 32'h10, 32'(lo));
         end
         asdma_far_inst.send(8, 10'h05A, 16);
      join
      chk("rx dma req", 32'h1, {31'h0, dma_rx_req});
      chk("rx dma data", 32'h5A, {23'h0, dma_rx_data});
      dma_rx_ack <= 1'b1;
      @(posedge clk);
      dma_rx_ack <= 1'b0;
      repeat (2) @(posedge clk);
      chk("rx dma drop", 32'h0, {31'h0, dma_rx_req});
   endtask : t_dma

   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_tx();
      t_rx();
      t_dma();
      end_sim();
   end
endmodule : tb

/* File: core/asdma_pkg.sv */
package asdma_pkg;

   // Byte addresses of the word-aligned registers on the bus.
   localparam logic [4:0] OFF_TXD  = 5'h00;
   localparam logic [4:0] OFF_RXD  = 5'h04;
   localparam logic [4:0] OFF_CFG  = 5'h08;
   localparam logic [4:0] OFF_DIVL = 5'h0C;
   localparam logic [4:0] OFF_DIVH = 5'h10;
   localparam logic [4:0] OFF_STAT = 5'h14;
   localparam logic [4:0] OFF_MASK = 5'h18;

   // Line format and data-path selection, bit 0 upward: wlen, stop2,
   // par_en, par_odd, mp, dtx, drx.
   typedef struct packed {
      logic       drx;
      logic       dtx;
      logic       mp;
      logic       par_odd;
      logic       par_en;
      logic       stop2;
      logic [1:0] wlen;
   } asdma_cfg_t;

   // Status word, bit 7 down to bit 0.
   typedef struct packed {
      logic tx_busy;
      logic addr;
      logic pe;
      logic fe;
      logic ovr;
      logic tx_full;
      logic tx_empty;
      logic rx_full;
   } asdma_stat_t;

   localparam logic [7:0]  CFG_RST   = 8'h03;
   localparam logic [7:0]  DIVL_RST  = 8'h01;
   localparam logic [7:0]  DIVH_RST  = 8'h00;
   localparam logic [1:0]  MASK_RST  = 2'h0;
   localparam logic [1:0]  PRIO_LOW  = 2'h0;
   localparam logic [2:0]  WLEN_MIN  = 3'h4;
   localparam logic [3:0]  OVS_LAST  = 4'hF;
   localparam logic [3:0]  OVS_MID   = 4'h7;
   localparam logic [3:0]  DMA_ROOM  = 4'h6;
   localparam int          FIFO_W    = 9;
   localparam int          FIFO_D    = 8;

   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} asdma_tx_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} asdma_rx_t;

endpackage : asdma_pkg

/* File: core/asdma_top.sv */
// Chosen here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps

module asdma_fifo #(
   parameter int W = 9,
   parameter int D = 8
) (
   input  wire logic                 clk,       // Clock.
   input  wire logic                 rst,       // Asynchronous reset.
   input  wire logic                 in_valid,  // Word offered.
   output logic                      in_ready,  // Room for a word.
   input  wire logic [W-1:0]         in_data,   // Word in.
   output logic                      out_valid, // Word available.
   input  wire logic                 out_ready, // Drain takes word.
   output logic [W-1:0]              out_data,  // Oldest word.
   output logic [$clog2(D):0]        count      // Words held.
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem [D];
   logic [AW-1:0] wp;
   logic [AW-1:0] rp;
   logic          push;
   logic          pop;

   assign in_ready  = count < (AW+1)'(D);
   assign out_valid = count != '0;
   assign out_data  = mem[rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp] <= in_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp    <= '0;
         rp    <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wp <= wp + 1'b1;
         end
         if (pop) begin
            rp <= rp + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule : asdma_fifo

module asdma_top (
   input  wire logic        clk,              // 125 MHz clock.
   input  wire logic        rst,              // Asynchronous reset.
   input  wire logic [4:0]  avs_address,      // Byte address.
   input  wire logic        avs_read,         // Read request.
   input  wire logic        avs_write,        // Write request.
   input  wire logic [31:0] avs_writedata,    // Write data.
   output logic [31:0]      avs_readdata,     // Read data.
   output logic             avs_waitrequest,  // Stall.
   input  wire logic        rxd,              // Serial in.
   output logic             txd,              // Serial out.
   output logic             dma_tx_req,       // Transmit DMA may push.
   input  wire logic        dma_tx_ack,       // Transmit word strobe.
   input  wire logic [8:0]  dma_tx_data,      // Transmit word.
   output logic             dma_rx_req,       // Received word waiting.
   input  wire logic        dma_rx_ack,       // Received word taken.
   output logic [8:0]       dma_rx_data,      // Received word.
   output logic [1:0]       dma_prio,         // DMA priority level.
   output logic             tx_irq,           // Transmit interrupt.
   output logic             rx_irq,           // Receive interrupt.
   output logic             rx_level          // Synced line for timer.
);
   asdma_pkg::asdma_cfg_t  cfg;
   asdma_pkg::asdma_stat_t stat;
   asdma_pkg::asdma_stat_t w1c;
   asdma_pkg::asdma_tx_t   tx_st;
   asdma_pkg::asdma_rx_t   rx_st;
   logic [7:0]  divl;
   logic [7:0]  divh;
   logic [1:0]  mask;
   logic [15:0] divisor;
   logic [15:0] div_last;
   logic [15:0] bcnt;
   logic        tick;
   logic        div_wr;
   logic        wr_go;
   logic        rd_go;
   logic        tx_acc;
   logic        rd_ok;
   logic [31:0] rd_mux;
   logic        f_push;
   logic [8:0]  f_din;
   logic        f_in_ready;
   logic        f_valid;
   logic        f_pop;
   logic [8:0]  f_dout;
   logic [3:0]  f_cnt;
   logic [2:0]  wl_last;
   logic [3:0]  tx_ovs;
   logic [2:0]  tx_bit;
   logic        tx_stopn;
   logic [7:0]  tx_sh;
   logic        tx_pbit;
   logic        r1;
   logic        r2;
   logic        r3;
   logic [3:0]  rx_ovs;
   logic [2:0]  rx_bit;
   logic [7:0]  rx_sh;
   logic        rx_pbit;
   logic        rx_done;
   logic        rx_fe;
   logic        rx_pe;
   logic        rx_full;
   logic        rx_clr;
   logic        ovr;
   logic        fe;
   logic        pe;

   function automatic logic par_of(input logic [7:0] d, input logic [1:0] wl, input logic odd);
      logic p;
      p = odd;
      for (int i = 0; i < 8; i++) begin
         if (i < int'(wl) + 5) begin
            p = p ^ d[i];
         end
      end
      return p;
   endfunction : par_of

   // Baud tick: one pulse every divisor cycles, sixteen per bit.
   assign divisor  = {divh, divl};
   assign div_last = (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001;
   assign div_wr   = wr_go && (avs_address == asdma_pkg::OFF_DIVL || avs_address == asdma_pkg::OFF_DIVH);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bcnt <= 16'h0000;
         tick <= 1'b0;
      end else if (div_wr) begin
         bcnt <= 16'h0000;
         tick <= 1'b0;
      end else if (bcnt >= div_last) begin
         bcnt <= 16'h0000;
         tick <= 1'b1;
      end else begin
         bcnt <= bcnt + 16'h0001;
         tick <= 1'b0;
      end
   end

   // Bus slave: the answer comes one cycle after a request that rd_ok or tx_acc lets through.
   assign wr_go  = avs_write && !avs_waitrequest;
   assign rd_go  = avs_read && !avs_waitrequest;
   assign tx_acc = (avs_address != asdma_pkg::OFF_TXD) || cfg.dtx || f_in_ready;
   // A read of the data register waits out a landing character so none is lost.
   assign rd_ok  = !(avs_address == asdma_pkg::OFF_RXD && rx_done);
   assign w1c    = asdma_pkg::asdma_stat_t'(avs_writedata[7:0]);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
      end else if (!avs_waitrequest) begin
         avs_waitrequest <= 1'b1;
      end else if ((avs_read && rd_ok) || (avs_write && tx_acc)) begin
         avs_waitrequest <= 1'b0;
      end
   end

   always_comb begin
      stat.rx_full  = rx_full;
      stat.tx_empty = !f_valid;
      stat.tx_full  = !f_in_ready;
      stat.ovr      = ovr;
      stat.fe       = fe;
      stat.pe       = pe;
      stat.addr     = dma_rx_data[8];
      stat.tx_busy  = tx_st != asdma_pkg::TX_IDLE;
   end

   always_comb begin
      if (avs_address == asdma_pkg::OFF_RXD) begin
         rd_mux = {23'h000000, dma_rx_data};
      end else if (avs_address == asdma_pkg::OFF_CFG) begin
         rd_mux = {24'h000000, cfg};
      end else if (avs_address == asdma_pkg::OFF_DIVL) begin
         rd_mux = {24'h000000, divl};
      end else if (avs_address == asdma_pkg::OFF_DIVH) begin
         rd_mux = {24'h000000, divh};
      end else if (avs_address == asdma_pkg::OFF_STAT) begin
         rd_mux = {24'h000000, stat};
      end else if (avs_address == asdma_pkg::OFF_MASK) begin
         rd_mux = {30'h00000000, mask};
      end else begin
         rd_mux = 32'h00000000;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read && avs_waitrequest && rd_ok) begin
         avs_readdata <= rd_mux;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg  <= asdma_pkg::asdma_cfg_t'(asdma_pkg::CFG_RST);
         divl <= asdma_pkg::DIVL_RST;
         divh <= asdma_pkg::DIVH_RST;
         mask <= asdma_pkg::MASK_RST;
      end else if (wr_go) begin
         if (avs_address == asdma_pkg::OFF_CFG) begin
            cfg <= asdma_pkg::asdma_cfg_t'(avs_writedata[7:0]);
         end else if (avs_address == asdma_pkg::OFF_DIVL) begin
            divl <= avs_writedata[7:0];
         end else if (avs_address == asdma_pkg::OFF_DIVH) begin
            divh <= avs_writedata[7:0];
         end else if (avs_address == asdma_pkg::OFF_MASK) begin
            mask <= avs_writedata[1:0];
         end
      end
   end

   // Transmit buffer: fed by the data register or by the transmit DMA channel.
   assign f_push = cfg.dtx ? dma_tx_ack : (wr_go && avs_address == asdma_pkg::OFF_TXD);
   assign f_din  = cfg.dtx ? dma_tx_data : avs_writedata[8:0];
   // Loading only on a tick keeps the start bit a full sixteen ticks long at any divisor.
   assign f_pop  = (tx_st == asdma_pkg::TX_IDLE) && tick;

   asdma_fifo #(
      .W(asdma_pkg::FIFO_W),
      .D(asdma_pkg::FIFO_D)
   ) u_txq (
      .clk      (clk),
      .rst      (rst),
      .in_valid (f_push),
      .in_ready (f_in_ready),
      .in_data  (f_din),
      .out_valid(f_valid),
      .out_ready(f_pop),
      .out_data (f_dout),
      .count    (f_cnt)
   );

   assign wl_last = {1'b0, cfg.wlen} + asdma_pkg::WLEN_MIN;

   // Transmitter. Word length, parity enable and stop2 are read live, so a format change can act on the character in flight.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_st    <= asdma_pkg::TX_IDLE;
         txd      <= 1'b1;
         tx_ovs   <= 4'h0;
         tx_bit   <= 3'h0;
         tx_stopn <= 1'b0;
         tx_sh    <= 8'h00;
         tx_pbit  <= 1'b0;
      end else begin
         case (tx_st)
            asdma_pkg::TX_IDLE: begin
               txd <= 1'b1;
               if (f_valid && tick) begin
                  tx_sh   <= f_dout[7:0];
                  tx_pbit <= cfg.mp ? f_dout[8] : par_of(f_dout[7:0], cfg.wlen, cfg.par_odd);
                  tx_ovs  <= 4'h0;
                  txd     <= 1'b0;
                  tx_st   <= asdma_pkg::TX_START;
               end
            end
            asdma_pkg::TX_START: begin
               if (tick) begin
                  tx_ovs <= tx_ovs + 4'h1;
                  if (tx_ovs == asdma_pkg::OVS_LAST) begin
                     txd    <= tx_sh[0];
                     tx_bit <= 3'h0;
                     tx_st  <= asdma_pkg::TX_DATA;
                  end
               end
            end
            asdma_pkg::TX_DATA: begin
               if (tick) begin
                  tx_ovs <= tx_ovs + 4'h1;
                  if (tx_ovs == asdma_pkg::OVS_LAST) begin
                     if (tx_bit == wl_last) begin
                        if (cfg.mp || cfg.par_en) begin
                           txd   <= tx_pbit;
                           tx_st <= asdma_pkg::TX_PAR;
                        end else begin
                           txd      <= 1'b1;
                           tx_stopn <= 1'b0;
                           tx_st    <= asdma_pkg::TX_STOP;
                        end
                     end else begin
                        tx_bit <= tx_bit + 3'h1;
                        tx_sh  <= {1'b0, tx_sh[7:1]};
                        txd    <= tx_sh[1];
                     end
                  end
               end
            end
            asdma_pkg::TX_PAR: begin
               if (tick) begin
                  tx_ovs <= tx_ovs + 4'h1;
                  if (tx_ovs == asdma_pkg::OVS_LAST) begin
                     txd      <= 1'b1;
                     tx_stopn <= 1'b0;
                     tx_st    <= asdma_pkg::TX_STOP;
                  end
               end
            end
            asdma_pkg::TX_STOP: begin
               if (tick) begin
                  tx_ovs <= tx_ovs + 4'h1;
                  if (tx_ovs == asdma_pkg::OVS_LAST) begin
                     if (cfg.stop2 && !tx_stopn) begin
                        tx_stopn <= 1'b1;
                     end else begin
                        tx_st <= asdma_pkg::TX_IDLE;
                     end
                  end
               end
            end
            default: tx_st <= asdma_pkg::TX_IDLE;
         endcase
      end
   end

   // Receive line synchroniser; serves edge detection, bit sampling and rx_level.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r1       <= 1'b1;
         r2       <= 1'b1;
         r3       <= 1'b1;
         rx_level <= 1'b1;
      end else begin
         r1       <= rxd;
         r2       <= r1;
         r3       <= r2;
         rx_level <= r2;
      end
   end

   // Receiver: start bit confirmed at its centre, then one sample per 16 ticks.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_st   <= asdma_pkg::RX_IDLE;
         rx_ovs  <= 4'h0;
         rx_bit  <= 3'h0;
         rx_sh   <= 8'h00;
         rx_pbit <= 1'b0;
         rx_done <= 1'b0;
         rx_fe   <= 1'b0;
         rx_pe   <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         case (rx_st)
            asdma_pkg::RX_IDLE: begin
               rx_ovs <= 4'h0;
               if (r3 && !r2) begin
                  rx_sh <= 8'h00;
                  rx_st <= asdma_pkg::RX_START;
               end
            end
            asdma_pkg::RX_START: begin
               if (tick) begin
                  rx_ovs <= rx_ovs + 4'h1;
                  if (rx_ovs == asdma_pkg::OVS_MID) begin
                     rx_ovs <= 4'h0;
                     rx_bit <= 3'h0;
                     rx_st  <= r2 ? asdma_pkg::RX_IDLE : asdma_pkg::RX_DATA;
                  end
               end
            end
            asdma_pkg::RX_DATA: begin
               if (tick) begin
                  rx_ovs <= rx_ovs + 4'h1;
                  if (rx_ovs == asdma_pkg::OVS_LAST) begin
                     rx_sh[rx_bit] <= r2;
                     rx_bit        <= rx_bit + 3'h1;
                     if (rx_bit == wl_last) begin
                        rx_st <= (cfg.mp || cfg.par_en) ? asdma_pkg::RX_PAR : asdma_pkg::RX_STOP;
                     end
                  end
               end
            end
            asdma_pkg::RX_PAR: begin
               if (tick) begin
                  rx_ovs <= rx_ovs + 4'h1;
                  if (rx_ovs == asdma_pkg::OVS_LAST) begin
                     rx_pbit <= r2;
                     rx_st   <= asdma_pkg::RX_STOP;
                  end
               end
            end
            asdma_pkg::RX_STOP: begin
               if (tick) begin
                  rx_ovs <= rx_ovs + 4'h1;
                  if (rx_ovs == asdma_pkg::OVS_LAST) begin
                     rx_done <= 1'b1;
                     rx_fe   <= !r2;
                     rx_pe   <= cfg.par_en && !cfg.mp && (rx_pbit != par_of(rx_sh, cfg.wlen, cfg.par_odd));
                     rx_st   <= asdma_pkg::RX_IDLE;
                  end
               end
            end
            default: rx_st <= asdma_pkg::RX_IDLE;
         endcase
      end
   end

   // Receive holding stage; a new character wins over a clear in the same cycle.
   assign rx_clr = (rd_go && avs_address == asdma_pkg::OFF_RXD) || dma_rx_ack;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dma_rx_data <= 9'h000;
         rx_full     <= 1'b0;
      end else if (rx_done) begin
         dma_rx_data <= {cfg.mp & rx_pbit, rx_sh};
         rx_full     <= 1'b1;
      end else if (rx_clr) begin
         rx_full <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ovr <= 1'b0;
         fe  <= 1'b0;
         pe  <= 1'b0;
      end else begin
         if (rx_done && rx_full && !rx_clr) begin
            ovr <= 1'b1;
         end else if (wr_go && avs_address == asdma_pkg::OFF_STAT && w1c.ovr) begin
            ovr <= 1'b0;
         end
         if (rx_done && rx_fe) begin
            fe <= 1'b1;
         end else if (wr_go && avs_address == asdma_pkg::OFF_STAT && w1c.fe) begin
            fe <= 1'b0;
         end
         if (rx_done && rx_pe) begin
            pe <= 1'b1;
         end else if (wr_go && avs_address == asdma_pkg::OFF_STAT && w1c.pe) begin
            pe <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dma_tx_req <= 1'b0;
         dma_rx_req <= 1'b0;
         dma_prio   <= asdma_pkg::PRIO_LOW;
         tx_irq     <= 1'b0;
         rx_irq     <= 1'b0;
      end else begin
         dma_tx_req <= cfg.dtx && (f_cnt < asdma_pkg::DMA_ROOM);
         dma_rx_req <= cfg.drx && rx_full && !dma_rx_ack;
         dma_prio   <= asdma_pkg::PRIO_LOW;
         tx_irq     <= mask[0] && !f_valid;
         rx_irq     <= mask[1] && rx_full;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_load;
      tx_st == asdma_pkg::TX_IDLE && f_valid && tick;
   endsequence
   sequence s_start_out;
      tx_st == asdma_pkg::TX_START && !txd;
   endsequence

   property p_idle_high;
      tx_st == asdma_pkg::TX_IDLE |-> txd;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("line not high while idle");

   property p_start_low;
      s_load |=> s_start_out;
   endproperty
   a_start_low: assert property (p_start_low) else $error("no start bit after load");

   property p_stop_high;
      tx_st == asdma_pkg::TX_STOP |-> txd && !(tx_stopn && !cfg.stop2);
   endproperty
   a_stop_high: assert property (p_stop_high) else $error("bad stop bit");

   property p_bits;
      tx_st == asdma_pkg::TX_DATA |-> tx_bit <= wl_last;
   endproperty
   a_bits: assert property (p_bits) else $error("too many data bits");

   property p_divh;
      wr_go && avs_address == asdma_pkg::OFF_DIVH |=> divisor[15:8] == $past(avs_writedata[7:0]);
   endproperty
   a_divh: assert property (p_divh) else $error("high divisor byte lost");

   property p_tick_gap;
      tick && div_last == 16'h0001 && $stable(div_last) && !div_wr |=> !tick ##1 (tick || $past(div_wr));
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("tick spacing wrong");

   property p_fe;
      rx_done && rx_fe |=> fe;
   endproperty
   a_fe: assert property (p_fe) else $error("framing error not flagged");

   property p_rx_clear;
      rd_go && avs_address == asdma_pkg::OFF_RXD && !rx_done |=> !rx_full;
   endproperty
   a_rx_clear: assert property (p_rx_clear) else $error("read did not free holding stage");

   property p_rx_req;
      dma_rx_req |-> $past(rx_full) && $past(cfg.drx);
   endproperty
   a_rx_req: assert property (p_rx_req) else $error("receive DMA request without data");

   property p_prio;
      dma_prio == asdma_pkg::PRIO_LOW;
   endproperty
   a_prio: assert property (p_prio) else $error("DMA priority not low");

   property p_irq;
      rx_irq |-> $past(mask[1]) && $past(rx_full);
   endproperty
   a_irq: assert property (p_irq) else $error("unmasked receive interrupt");

   property p_ack_one;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("waitrequest low too long");

endmodule : asdma_top
